/* ocfr_core.sv */
// Output-current fault response: action registers, average thresholds, retry engines
//
// Functional notes
// - Undercurrent action byte resets to 80h.
// - Any current fault pulls alert, sets sticky bit.
// - Undercurrent sets the undercurrent bit only.
// - Mode 10 disables at once, then follows the retry field.
// - Mode 11 resumes once fault disappears.
// - Retry 000 holds output off until cleared.
// - Retry 111 restarts endlessly until stopped.
// - Retry spacing is (delay+1) times 35 ms.
// - Thresholds are two-byte Linear-11 read-write values.
// - Thresholds accepted within minus to plus 100 A.
// - Average overcurrent threshold resets from pin strap.
// - Down-slope averages off-time samples after blanking.
// - Up-slope averages on-time samples after blanking.
// - Average overcurrent shares overcurrent bit and response.
// - Average undercurrent shares undercurrent bit and response.
// - Overcurrent action byte same layout, 80h reset.
// - Average undercurrent resets to negated strap threshold.
`timescale 1ns/1ps
`default_nettype none
module ocfr_core
    import ocfr_pkg::*;
#(
    parameter int RETRY_UNIT_CYC = OCFR_RETRY_UNIT_CYC, // Cycles per 35 ms unit
    parameter int CNT_W          = 8                    // Sample counter width
) (
    input  wire logic         clk_sys,        // System clock, 40 MHz
    input  wire logic         sys_rst,        // Synchronous reset, active high
    input  wire ocfr_req_t    req,            // Register request
    output logic [15:0]       rdata,          // Read data, registered
    output logic              rvalid,         // Read data valid pulse
    input  wire logic [15:0]  strap_oc_limit, // Pin-strap average OC threshold
    input  wire logic         clear_faults,   // Clear-faults command pulse
    input  wire logic         sense_up,       // 1: up-slope sensing, 0: down-slope
    input  wire ocfr_sample_t sample,         // Current-sense sample
    input  wire logic         cycle_end,      // End of switching cycle pulse
    input  wire logic         inst_oc,        // Instantaneous overcurrent level
    input  wire logic         inst_uc,        // Instantaneous undercurrent level
    input  wire logic         off_cmd,        // Output commanded off
    input  wire logic         bias_ok,        // Bias power present
    input  wire logic         other_fault,    // Another shutdown fault
    output logic              output_en,      // Output enable to power stage
    output logic [7:0]        status_iout,    // Output-current status byte
    output logic              fault_alert_line_o,  // Alert pin drive level (always 0)
    output logic              fault_alert_line_oe  // Alert pin enable, high pulls low
);

    // Linear-11 to fixed point with clamp to the accepted span
    function automatic logic signed [15:0] lin_to_fix(input logic [15:0] lin);
        logic signed [31:0] mant;
        logic signed [31:0] sh;
        logic signed [31:0] v;
        logic signed [31:0] lim;
        mant = 32'(signed'(lin[OCFR_LIN_MANT_W-1:0]));
        sh   = 32'(signed'(lin[15:OCFR_LIN_EXP_LSB])) + OCFR_FIX_FRAC;
        lim  = OCFR_LIMIT_AMPS << OCFR_FIX_FRAC;
        if (sh >= 0) begin
            v = mant <<< sh[4:0];
        end else begin
            v = mant >>> (-sh);
        end
        if (v > lim) begin          // Beyond the span saturates
            v = lim;
        end else if (v < -lim) begin
            v = -lim;
        end
        return v[15:0];
    endfunction

    // Register and status state
    ocfr_action_t act_r   [2];     // Action bytes: OC, UC
    ocfr_action_t act_nxt [2];
    logic [15:0]  thr_r   [2];     // Linear-11 thresholds: OC, UC
    logic [15:0]  thr_nxt [2];
    logic         strap_done_r;    // Strap loaded after reset release
    logic         strap_done_nxt;
    logic [1:0]   stat_r;          // Sticky fault bits: [0] OC, [1] UC
    logic [1:0]   stat_nxt;
    logic [15:0]  rdata_nxt;       // Read data next
    logic         rvalid_nxt;

    // Averaging state
    logic signed [23:0] sum_r;     // Sample sum over the window
    logic signed [23:0] sum_nxt;
    logic [CNT_W-1:0]   cnt_r;     // Samples in the window
    logic [CNT_W-1:0]   cnt_nxt;
    logic [1:0]         avg_r;     // Last cycle's average results
    logic [1:0]         avg_nxt;
    logic [1:0]         avg_ev;    // Average crossing this cycle
    logic               in_win;    // Sample lies in the averaging window
    logic signed [24:0] lim_oc;    // OC threshold times count
    logic signed [24:0] lim_uc;    // UC threshold times count
    logic [1:0]         fault_now; // Fault events this cycle
    logic [1:0]         fault_lvl; // Fault presence level
    logic               stop_req;  // Conditions that end retrying

    // Response engines
    ocfr_state_t  st_r    [2];
    ocfr_state_t  st_nxt  [2];
    logic [31:0]  div_r   [2];     // Divider toward one 35 ms tick
    logic [31:0]  div_nxt [2];
    logic [2:0]   unit_r  [2];     // Elapsed 35 ms units
    logic [2:0]   unit_nxt[2];
    logic [1:0]   tick;            // One-cycle 35 ms enable

    // Register file: writes, strap capture, reads
    always_comb begin
        act_nxt        = act_r;
        thr_nxt        = thr_r;
        strap_done_nxt = 1'b1;
        rdata_nxt      = rdata;
        rvalid_nxt     = req.rd;
        if (!strap_done_r) begin
            // Strap is sampled once after release, never under reset
            thr_nxt[OCFR_FLT_OC] = strap_oc_limit;
            thr_nxt[OCFR_FLT_UC] = {strap_oc_limit[15:OCFR_LIN_EXP_LSB],
                                    11'(-strap_oc_limit[OCFR_LIN_MANT_W-1:0])};
        end else if (req.wr) begin
            case (req.cmd)
                OCFR_CMD_OC_ACT: act_nxt[OCFR_FLT_OC] = req.wdata[7:0];
                OCFR_CMD_UC_ACT: act_nxt[OCFR_FLT_UC] = req.wdata[7:0];
                OCFR_CMD_AVG_OC: thr_nxt[OCFR_FLT_OC] = req.wdata;
                OCFR_CMD_AVG_UC: thr_nxt[OCFR_FLT_UC] = req.wdata;
                default: ;  // Unmapped codes are ignored
            endcase
        end
        if (req.rd) begin
            case (req.cmd)
                OCFR_CMD_OC_ACT: rdata_nxt = {8'h00, act_r[OCFR_FLT_OC]};
                OCFR_CMD_UC_ACT: rdata_nxt = {8'h00, act_r[OCFR_FLT_UC]};
                OCFR_CMD_AVG_OC: rdata_nxt = thr_r[OCFR_FLT_OC];
                OCFR_CMD_AVG_UC: rdata_nxt = thr_r[OCFR_FLT_UC];
                default:         rdata_nxt = 16'h0000;  // Unmapped reads zero
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            act_r[0]     <= OCFR_ACT_RESET;
            act_r[1]     <= OCFR_ACT_RESET;
            thr_r[0]     <= 16'h0000;
            thr_r[1]     <= 16'h0000;
            strap_done_r <= 1'b0;
            rdata        <= 16'h0000;
            rvalid       <= 1'b0;
        end else begin
            act_r        <= act_nxt;
            thr_r        <= thr_nxt;
            strap_done_r <= strap_done_nxt;
            rdata        <= rdata_nxt;
            rvalid       <= rvalid_nxt;
        end
    end

    // Averaging window: on-time for up-slope, off-time for down-slope, blanking skipped
    assign in_win = sample.valid && !sample.blank && (sample.on_ph == sense_up);
    // Compare sum against threshold times count, which avoids a divider
    assign lim_oc = 25'(lin_to_fix(thr_r[OCFR_FLT_OC]) * $signed({1'b0, cnt_r}));
    assign lim_uc = 25'(lin_to_fix(thr_r[OCFR_FLT_UC]) * $signed({1'b0, cnt_r}));

    always_comb begin
        sum_nxt = sum_r;
        cnt_nxt = cnt_r;
        avg_nxt = avg_r;
        avg_ev  = 2'b00;
        if (cycle_end) begin
            // One decision per switching cycle; an empty window gives none
            if (cnt_r != '0) begin
                avg_ev[OCFR_FLT_OC] = 25'(sum_r) > lim_oc;
                avg_ev[OCFR_FLT_UC] = 25'(sum_r) < lim_uc;
            end
            avg_nxt = avg_ev;
            sum_nxt = '0;
            cnt_nxt = '0;
        end else if (in_win && cnt_r != '1) begin
            // Counter saturation bounds the sum width
            sum_nxt = sum_r + 24'(sample.value);
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Averaging flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sum_r <= '0;
            cnt_r <= '0;
            avg_r <= 2'b00;
        end else begin
            sum_r <= sum_nxt;
            cnt_r <= cnt_nxt;
            avg_r <= avg_nxt;
        end
    end

    // Average and instantaneous limits feed one response path per fault type
    assign fault_now = {inst_uc | avg_ev[OCFR_FLT_UC], inst_oc | avg_ev[OCFR_FLT_OC]};
    assign fault_lvl = {inst_uc | avg_r[OCFR_FLT_UC], inst_oc | avg_r[OCFR_FLT_OC]};
    assign stop_req  = off_cmd | !bias_ok | other_fault;

    // Sticky status; a new fault beats a clear in the same cycle
    assign stat_nxt = fault_now | (stat_r & {2{!clear_faults}});

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stat_r <= 2'b00;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Status byte and open-drain alert
    always_comb begin
        status_iout                   = 8'h00;
        status_iout[OCFR_STAT_OC_BIT] = stat_r[OCFR_FLT_OC];
        status_iout[OCFR_STAT_UC_BIT] = stat_r[OCFR_FLT_UC];
    end
    assign fault_alert_line_o  = 1'b0;
    assign fault_alert_line_oe = |stat_r;

    // One response engine per fault type
    for (genvar i = 0; i < 2; i++) begin : g_eng
        assign tick[i] = (div_r[i] == 32'(RETRY_UNIT_CYC - 1));

        always_comb begin
            st_nxt[i]   = st_r[i];
            div_nxt[i]  = 32'h0000_0000;
            unit_nxt[i] = 3'b000;
            case (st_r[i])
                OCFR_ST_RUN: begin
                    if (fault_now[i]) begin
                        if (act_r[i].mode == OCFR_MODE_WHILE) begin
                            st_nxt[i] = OCFR_ST_WAIT;
                        end else if (act_r[i].retry == OCFR_RETRY_FOREVER) begin
                            st_nxt[i] = OCFR_ST_RETRY;
                        end else begin
                            // Unused retry codes behave as no retry
                            st_nxt[i] = OCFR_ST_HOLD;
                        end
                    end
                end
                OCFR_ST_WAIT: begin
                    if (!fault_lvl[i]) begin
                        st_nxt[i] = OCFR_ST_RUN;
                    end
                end
                OCFR_ST_RETRY: begin
                    div_nxt[i]  = tick[i] ? 32'h0000_0000 : div_r[i] + 1;
                    unit_nxt[i] = tick[i] ? unit_r[i] + 1'b1 : unit_r[i];
                    if (stop_req) begin
                        st_nxt[i] = OCFR_ST_HOLD;
                    end else if (tick[i] && unit_r[i] == act_r[i].delay) begin
                        // Restart whether or not the fault is still there
                        st_nxt[i] = OCFR_ST_RUN;
                    end
                end
                OCFR_ST_HOLD: begin
                    if (clear_faults) begin
                        st_nxt[i] = OCFR_ST_RUN;
                    end
                end
                default: st_nxt[i] = OCFR_ST_HOLD;  // Illegal code shuts down
            endcase
        end

        // Engine flops
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                st_r[i]   <= OCFR_ST_RUN;
                div_r[i]  <= 32'h0000_0000;
                unit_r[i] <= 3'b000;
            end else begin
                st_r[i]   <= st_nxt[i];
                div_r[i]  <= div_nxt[i];
                unit_r[i] <= unit_nxt[i];
            end
        end

        // Checks: helper age of the current retry wait
        logic [31:0] age_r;
        always_ff @(posedge clk_sys) begin
            if (sys_rst || st_r[i] != OCFR_ST_RETRY) begin
                age_r <= 32'h0000_0000;
            end else begin
                age_r <= age_r + 1;
            end
        end

        sequence s_retry_end;
            st_r[i] == OCFR_ST_RETRY ##1 st_r[i] == OCFR_ST_RUN;
        endsequence

        chk_retry_span: assert property (@(posedge clk_sys) disable iff (sys_rst)
            s_retry_end |-> $past(age_r) + 1 ==
                32'((act_r[i].delay + 1) * RETRY_UNIT_CYC))
            else $error("retry spacing wrong");

        chk_mode_off_now: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (st_r[i] == OCFR_ST_RUN && fault_now[i] && act_r[i].mode == OCFR_MODE_RETRY)
            |=> !output_en)
            else $error("output not disabled at fault");

        chk_resume_gone: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (st_r[i] == OCFR_ST_WAIT && !fault_lvl[i]) |=> st_r[i] == OCFR_ST_RUN)
            else $error("no resume after fault gone");

        chk_hold_stays: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (st_r[i] == OCFR_ST_HOLD && !clear_faults) |=> st_r[i] == OCFR_ST_HOLD)
            else $error("hold left without clear");

        chk_retry_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (st_r[i] == OCFR_ST_RETRY && stop_req) |=> st_r[i] == OCFR_ST_HOLD)
            else $error("retry not stopped");
    end

    // Output allowed only while both engines run
    assign output_en = (st_r[0] == OCFR_ST_RUN) && (st_r[1] == OCFR_ST_RUN);

    chk_uc_reset: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> act_r[OCFR_FLT_UC] == OCFR_ACT_RESET)
        else $error("undercurrent action reset wrong");

    chk_alert_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (|fault_now) |=> fault_alert_line_oe [*1] ##0 (|stat_r))
        else $error("alert not raised on fault");

    chk_uc_bit_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (fault_now == 2'b10 && !stat_r[OCFR_FLT_OC])
        |=> status_iout[OCFR_STAT_UC_BIT] && !status_iout[OCFR_STAT_OC_BIT])
        else $error("undercurrent set wrong bit");

    chk_strap_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !strap_done_r |=> thr_r[OCFR_FLT_OC] == $past(strap_oc_limit)
            && thr_r[OCFR_FLT_UC][10:0] == 11'(-$past(strap_oc_limit[10:0])))
        else $error("strap thresholds not loaded");

    chk_avg_oc: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cycle_end && cnt_r != '0 && 25'(sum_r) > lim_oc) |=> stat_r[OCFR_FLT_OC])
        else $error("average overcurrent not flagged");

    chk_window: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!cycle_end && !in_win) |=> cnt_r == $past(cnt_r))
        else $error("sample outside window counted");

endmodule
`default_nettype wire

/* ocfr_host.sv */
// Host model: register writes and reads on the block's request port
`timescale 1ns/1ps
`default_nettype none
module ocfr_host
    import ocfr_pkg::*;
(
    input  wire logic        clk_sys, // System clock
    output ocfr_req_t        req,     // Request to the block
    input  wire logic [15:0] rdata,   // Read data
    input  wire logic        rvalid   // Read data valid pulse
);
    // Bus idles with no strobe raised
    initial req = '0;

    // One write: held over its taking edge, then one idle edge before the next
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        req = '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
        @(posedge clk_sys);
        #2 req = '0;
        @(posedge clk_sys);
        #2;
    endtask

    // One read: data is taken at the rvalid pulse; ok stays low on a timeout
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output bit ok);
        ok = 0;
        d = 'x;
        req = '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
        @(posedge clk_sys);
        #2 req = '0;
        // Bounded wait, the pulse stands one cycle only
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rvalid === 1'b1) begin
                ok = 1;
                d = rdata;
            end else begin
                @(posedge clk_sys);
                #2;
            end
        end
        // One idle edge, so a following request never lands in the step that cleared req
        @(posedge clk_sys);
        #2;
    endtask
endmodule
`default_nettype wire

/* ocfr_pkg.sv */
// Package: constants, field layouts and types for the output-current fault response block
package ocfr_pkg;

    // Command codes at which the registers stand
    localparam logic [7:0]  OCFR_CMD_OC_ACT   = 8'hE5;   // Overcurrent action byte
    localparam logic [7:0]  OCFR_CMD_UC_ACT   = 8'hE6;   // Undercurrent action byte
    localparam logic [7:0]  OCFR_CMD_AVG_OC   = 8'hE7;   // Average overcurrent threshold
    localparam logic [7:0]  OCFR_CMD_AVG_UC   = 8'hE8;   // Average undercurrent threshold

    // Action byte reset value and field codes
    localparam logic [7:0]  OCFR_ACT_RESET    = 8'h80;   // Immediate shutdown, no retries
    localparam logic [1:0]  OCFR_MODE_RETRY   = 2'b10;   // Disable now, then follow retry field
    localparam logic [1:0]  OCFR_MODE_WHILE   = 2'b11;   // Off only while fault persists
    localparam logic [2:0]  OCFR_RETRY_NONE   = 3'b000;  // Stay off until cleared
    localparam logic [2:0]  OCFR_RETRY_FOREVER = 3'b111; // Restart without end

    // Linear-11 layout: exponent in 15:11, mantissa in 10:0
    localparam int          OCFR_LIN_EXP_LSB  = 11;      // Exponent position
    localparam int          OCFR_LIN_MANT_W   = 11;      // Mantissa width
    localparam int          OCFR_FIX_FRAC     = 4;       // Sample fraction bits (1/16 A)
    localparam int          OCFR_LIMIT_AMPS   = 100;     // Accepted magnitude of thresholds

    // Status bits reported on the status port
    localparam int          OCFR_STAT_OC_BIT  = 7;       // Overcurrent fault bit
    localparam int          OCFR_STAT_UC_BIT  = 4;       // Undercurrent fault bit

    // Fault indices inside the response engines
    localparam int          OCFR_FLT_OC       = 0;       // Overcurrent engine
    localparam int          OCFR_FLT_UC       = 1;       // Undercurrent engine

    // Timing: retry delay unit
    localparam int          OCFR_CLK_HZ       = 40_000_000;    // System clock rate
    localparam int          OCFR_RETRY_UNIT_MS = 35;           // Retry unit in ms
    localparam int          OCFR_RETRY_UNIT_CYC = OCFR_CLK_HZ / 1000 * OCFR_RETRY_UNIT_MS;

    // Action byte layout: mode 7:6, retry 5:3, delay 2:0
    typedef struct packed {
        logic [1:0] mode;   // Response mode
        logic [2:0] retry;  // Retry setting
        logic [2:0] delay;  // Retry delay units minus one
    } ocfr_action_t;

    // Register request from the management interface
    typedef struct packed {
        logic        wr;    // Write strobe
        logic        rd;    // Read strobe
        logic [7:0]  cmd;   // Command code
        logic [15:0] wdata; // Write data
    } ocfr_req_t;

    // One current-sense sample with its phase marks
    typedef struct packed {
        logic               valid;  // Sample strobe
        logic               on_ph;  // High during the D interval
        logic               blank;  // High during blanking
        logic signed [15:0] value;  // Current, 1/16 A units
    } ocfr_sample_t;

    // Response engine states
    typedef enum logic [3:0] {
        OCFR_ST_RUN   = 4'b0001,  // Output allowed
        OCFR_ST_HOLD  = 4'b0010,  // Off until faults cleared
        OCFR_ST_WAIT  = 4'b0100,  // Off while fault persists
        OCFR_ST_RETRY = 4'b1000   // Off, timing next restart
    } ocfr_state_t;

endpackage

/* output_current_fault_response_tb_top.sv */
// Testbench: register, average-current and fault-engine checks of the response block
`timescale 1ns/1ps
`default_nettype none
module output_current_fault_response_tb_top
    import ocfr_pkg::*;
;
    logic         clk_sys = 0;    // 40 MHz clock
    logic         sys_rst, clear_faults, sense_up, cycle_end, inst_oc, inst_uc;
    logic         off_cmd, bias_ok, other_fault, output_en, rvalid, alert_o, alert_oe;
    ocfr_req_t    req;            // Request from host model
    ocfr_sample_t sample;         // Current-sense sample
    logic [15:0]  rdata;          // Read data
    logic [7:0]   status_iout;    // Status byte
    logic [15:0]  strap = 16'h0050; // Strap threshold, 80 A
    int           errors, comparisons, toc, tuc, d, cnt, rises;
    logic signed [15:0] vin, vout; // In-window and excluded sample values
    bit           eoc, euc;       // Expected fault flags

    // Short retry unit keeps the retry timing visible in a short run
    ocfr_core #(.RETRY_UNIT_CYC(10)) ocfr_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .req(req), .rdata(rdata), .rvalid(rvalid), .strap_oc_limit(strap),
        .clear_faults(clear_faults), .sense_up(sense_up), .sample(sample),
        .cycle_end(cycle_end), .inst_oc(inst_oc), .inst_uc(inst_uc), .off_cmd(off_cmd),
        .bias_ok(bias_ok), .other_fault(other_fault), .output_en(output_en),
        .status_iout(status_iout), .fault_alert_line_o(alert_o),
        .fault_alert_line_oe(alert_oe));
    ocfr_host ocfr_host_inst (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));

    // Clock generator
    always #12.5 clk_sys = ~clk_sys;

    // Linear-11 word with exponent zero
    function automatic logic [15:0] lin(input int a);
        return {5'h00, 11'(a)};
    endfunction
    // Same exponent, negated mantissa
    function automatic logic [15:0] negm(input logic [15:0] v);
        return {v[15:11], 11'(-v[10:0])};
    endfunction
    // Fault expected when the mean passes the threshold in amperes
    function automatic bit beyond(input int v, input int amps, input bit over);
        return over ? (v > amps * 16) : (v < amps * 16);
    endfunction

    // Counted comparison, reports a mismatch at once
    task automatic check(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            errors++;
            $display("ERROR at %0t ns: %s", $time, m);
        end
    endtask
    // Advance n edges and settle just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Read a register and compare with the expected word
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        bit          ok;
        ocfr_host_inst.rd(c, v, ok);
        check(ok && v === e, "register read mismatch");
    endtask
    // Pulse clear-faults, then expect a clean running output
    task automatic clear_chk();
        clear_faults = 1;
        tick(1);
        clear_faults = 0;
        tick(2);
        check(status_iout === 8'h00 && output_en === 1'b1 && alert_oe === 1'b0, "clear failed");
    endtask
    // One switching cycle: blanked and wrong-phase samples carry the excluded value
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            sample = '{1'b1, sense_up, 1'b1, vout};
            tick(1);
            sample = '{1'b1, !sense_up, 1'b0, vout};
            tick(1);
            sample = '{1'b1, sense_up, 1'b0, vin};
            tick(1);
        end
        sample = '0;
        cycle_end = 1;
        tick(1);
        cycle_end = 0;
        tick(2);
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, well beyond the longest scenario
    initial begin
        #(25 * 100000);
        errors++;
        $display("ERROR at %0t ns: run timed out", $time);
        complete_run();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h91ca_ddcf));
        {sys_rst, bias_ok} = 2'b11;
        {clear_faults, sense_up, cycle_end, inst_oc, inst_uc, off_cmd, other_fault} = '0;
        sample = '0;
        repeat (5) @(posedge clk_sys);
        #2 sys_rst = 0;
        tick(2);
        // Reset state and reset register values
        check(status_iout === 8'h00 && output_en === 1'b1 && alert_oe === 1'b0, "reset state");
        rd_chk(OCFR_CMD_UC_ACT, 16'h0080);
        rd_chk(OCFR_CMD_OC_ACT, 16'h0080);
        rd_chk(OCFR_CMD_AVG_OC, strap);
        rd_chk(OCFR_CMD_AVG_UC, negm(strap));
        rd_chk(8'hE4, 16'h0000);
        // Averaged thresholds, both sensing modes, default hold response
        for (int k = 0; k < 8; k++) begin
            sense_up = k[0];
            toc = (k < 4) ? $urandom_range(20, 90) : 100;
            tuc = (k < 4) ? -100 : $urandom_range(10, 50);
            vin = 16'((k < 4 ? toc : tuc) * 16 + (k[1] ? 1 : -1) * $urandom_range(1, 200));
            eoc = beyond(vin, toc, 1);
            euc = beyond(vin, tuc, 0);
            // Excluded value chosen so that counting it would flip the overcurrent verdict
            vout = eoc ? 16'sh0000 - 16'sh0bb8 : 16'sh0bb8;
            ocfr_host_inst.wr(OCFR_CMD_AVG_OC, lin(toc));
            ocfr_host_inst.wr(OCFR_CMD_AVG_UC, lin(tuc));
            rd_chk(OCFR_CMD_AVG_OC, lin(toc));
            rd_chk(OCFR_CMD_AVG_UC, lin(tuc));
            burst($urandom_range(1, 6));
            check(status_iout[7] === eoc && status_iout[4] === euc, "avg bits");
            check(alert_oe === (eoc | euc) && alert_o === 1'b0, "alert line");
            tick(90);
            check(output_en === !(eoc | euc), "hold after fault");
            clear_chk();
        end
        // Off only while the fault is present
        ocfr_host_inst.wr(OCFR_CMD_UC_ACT, 16'h00C0);
        rd_chk(OCFR_CMD_UC_ACT, 16'h00C0);
        inst_uc = 1;
        tick(6);
        check(output_en === 1'b0, "off while fault present");
        inst_uc = 0;
        tick(3);
        check(output_en === 1'b1 && status_iout === 8'h10, "resume, bit sticky");
        clear_chk();
        // Retry spacing for several delay codes
        for (int k = 0; k < 3; k++) begin
            d = (k == 2) ? 7 : $urandom_range(0, 6);
            ocfr_host_inst.wr(OCFR_CMD_OC_ACT, {8'h00, 5'b10111, 3'(d)});
            inst_oc = 1;
            tick(1);
            inst_oc = 0;
            cnt = 0;
            while (output_en === 1'b0 && cnt < 1000) begin
                cnt++;
                tick(1);
            end
            check(cnt >= (d + 1) * 10 - 1 && cnt <= (d + 1) * 10 + 1, "retry spacing");
            clear_chk();
        end
        // Persistent fault: restarts go on without checking, an off command stops them
        inst_oc = 1;
        rises = 0;
        for (int i = 0; i < 300; i++) begin
            tick(1);
            rises += (output_en === 1'b1) ? 1 : 0;
        end
        check(rises >= 2, "continuous restarts");
        off_cmd = 1;
        inst_oc = 0;
        tick(120);
        check(output_en === 1'b0, "off command ends retry");
        off_cmd = 0;
        clear_chk();
        complete_run();
    end
endmodule
`default_nettype wire
